// ===== rtl/dpmc_defines.vh
`ifndef DPMC_DEFINES_VH
`define DPMC_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define DPMC_IDX_MODE        10'h200
`define DPMC_IDX_DECIM       10'h201
`define DPMC_IDX_OFFSET      10'h228
`define DPMC_IDX_LVL_CTRL    10'h245

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPMC_RST_MODE        8'h00
`define DPMC_RST_DECIM       8'h00
`define DPMC_RST_OFFSET      8'h00
`define DPMC_RST_LVL_CTRL    8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPMC_MODE_RSV_HI     7
`define DPMC_MODE_RSV_LO     6
`define DPMC_MODE_QDROP_BIT  5
`define DPMC_MODE_APP_HI     3
`define DPMC_MODE_APP_LO     0
`define DPMC_DECIM_HI        2
`define DPMC_DECIM_LO        0
`define DPMC_LVL_FORCE_BIT   3
`define DPMC_LVL_FVAL_BIT    2
`define DPMC_LVL_EN_BIT      0

// ----------------------------------------
// Application mode codes
// ----------------------------------------
`define DPMC_APP_FULL_BW     4'h0
`define DPMC_APP_ONE_CHAN    4'h1
`define DPMC_APP_TWO_CHAN    4'h2

// ----------------------------------------
// Decimation ratio codes
// ----------------------------------------
`define DPMC_DEC_1           3'h0
`define DPMC_DEC_2           3'h1
`define DPMC_DEC_4           3'h2
`define DPMC_DEC_8           3'h3
`define DPMC_DEC_16          3'h4

`endif

// ===== rtl/dpmc_offset_add.v
`timescale 1ns/1ps

// ----------------------------------------
// Signed sample plus signed 8-bit offset, saturated
// ----------------------------------------
module dpmc_offset_add #(
	parameter SAMPLE_W = 14
) (
	// Operands
	input  wire signed [SAMPLE_W-1:0] i_sample,
	input  wire signed [7:0]          i_offset,
	// Result
	output reg  signed [SAMPLE_W-1:0] o_sum
);

	wire signed [SAMPLE_W:0] sum_wide;
	wire signed [SAMPLE_W:0] max_val;
	wire signed [SAMPLE_W:0] min_val;

	// One count of offset is one converter LSB
	assign sum_wide = {i_sample[SAMPLE_W-1], i_sample} +
		{{(SAMPLE_W-7){i_offset[7]}}, i_offset};
	assign max_val = {2'b00, {(SAMPLE_W-1){1'b1}}};
	assign min_val = {2'b11, {(SAMPLE_W-1){1'b0}}};

	// Clip instead of wrapping at full scale
	always @* begin
		if (sum_wide > max_val) begin
			o_sum = max_val[SAMPLE_W-1:0];
		end else if (sum_wide < min_val) begin
			o_sum = min_val[SAMPLE_W-1:0];
		end else begin
			o_sum = sum_wide[SAMPLE_W-1:0];
		end
	end

endmodule // dpmc_offset_add

// ===== rtl/dpmc_datapath_regs.v
`timescale 1ns/1ps
`include "dpmc_defines.vh"

// Operation
// - Bit 5 set drops quadrature, keeps real
// - Mode 0000 full bandwidth, 0001 channel 0
// - Mode 0010 enables channels 0 and 1
// - Decimation codes 000..100 divide 1..16
// - Add signed 8-bit offset in converter LSBs
// - Force bit chooses forced level-detect pin
// - Forced pin takes value of bit 2
module dpmc_datapath_regs #(
	parameter SAMPLE_W = 14,
	parameter NUM_CHAN = 4
) (
	// Clock and reset
	input  wire                       i_mclk,
	input  wire                       i_rst,
	// Avalon-MM slave
	input  wire [11:0]                i_avs_address,
	input  wire                       i_avs_read,
	input  wire                       i_avs_write,
	input  wire [31:0]                i_avs_writedata,
	input  wire [3:0]                 i_avs_byteenable,
	output reg  [31:0]                o_avs_readdata,
	output wire                       o_avs_waitrequest,
	// Sample input
	input  wire                       i_smp_valid,
	input  wire signed [SAMPLE_W-1:0] i_smp_i,
	input  wire signed [SAMPLE_W-1:0] i_smp_q,
	// Sample output
	output reg                        o_smp_valid,
	output reg                        o_smp_q_valid,
	output reg  signed [SAMPLE_W-1:0] o_smp_i,
	output reg  signed [SAMPLE_W-1:0] o_smp_q,
	// Datapath configuration
	output reg                        o_full_bw,
	output reg  [NUM_CHAN-1:0]        o_downconverter_channel_en,
	output reg  [4:0]                 o_decim_factor,
	// Level detect
	input  wire                       i_level_detect_raw,
	output reg                        o_level_detect_pin
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]                 mode_reg;
	reg  [7:0]                 decim_reg;
	reg  [7:0]                 offset_reg;
	reg  [7:0]                 lvl_ctrl_reg;
	reg                        ack_reg;
	reg  [3:0]                 phase_reg;

	reg  [7:0]                 rd_byte;
	reg  [3:0]                 phase_max;
	reg  [4:0]                 factor_next;
	reg  [NUM_CHAN-1:0]        chan_en_next;
	reg                        full_bw_next;

	wire [9:0]                 reg_idx;
	wire                       req;
	wire                       wr_fire;
	wire signed [SAMPLE_W-1:0] adj_i;
	wire signed [SAMPLE_W-1:0] adj_q;
	wire                       q_drop;
	wire [3:0]                 app_mode;
	wire [2:0]                 decim_code;

	assign reg_idx  = i_avs_address[11:2];
	assign req      = i_avs_read | i_avs_write;
	// One wait cycle per access; read data is loaded during it
	assign o_avs_waitrequest = req & ~ack_reg;
	assign wr_fire  = i_avs_write & ack_reg & i_avs_byteenable[0];

	assign q_drop     = mode_reg[`DPMC_MODE_QDROP_BIT];
	assign app_mode   = mode_reg[`DPMC_MODE_APP_HI:`DPMC_MODE_APP_LO];
	assign decim_code = decim_reg[`DPMC_DECIM_HI:`DPMC_DECIM_LO];

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Reserved bits read zero except the storing mode bits 7:6
	always @* begin
		case (reg_idx)
		`DPMC_IDX_MODE:     rd_byte = {mode_reg[7:5], 1'b0, mode_reg[3:0]};
		`DPMC_IDX_DECIM:    rd_byte = {5'h00, decim_reg[2:0]};
		`DPMC_IDX_OFFSET:   rd_byte = offset_reg;
		`DPMC_IDX_LVL_CTRL: rd_byte = {4'h0, lvl_ctrl_reg[3:2], 1'b0, lvl_ctrl_reg[0]};
		default:            rd_byte = 8'h00;
		endcase
	end

	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read & ~ack_reg) begin
			o_avs_readdata <= {24'h00_0000, rd_byte};
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (i_rst) begin
			mode_reg     <= `DPMC_RST_MODE;
			decim_reg    <= `DPMC_RST_DECIM;
			offset_reg   <= `DPMC_RST_OFFSET;
			lvl_ctrl_reg <= `DPMC_RST_LVL_CTRL;
		end else if (wr_fire) begin
			case (reg_idx)
			`DPMC_IDX_MODE:     mode_reg     <= {i_avs_writedata[7:5], 1'b0, i_avs_writedata[3:0]};
			`DPMC_IDX_DECIM:    decim_reg    <= {5'h00, i_avs_writedata[2:0]};
			`DPMC_IDX_OFFSET:   offset_reg   <= i_avs_writedata[7:0];
			`DPMC_IDX_LVL_CTRL: lvl_ctrl_reg <= {4'h0, i_avs_writedata[3:2], 1'b0, i_avs_writedata[0]};
			default:            mode_reg     <= mode_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	always @* begin
		full_bw_next = 1'b0;
		chan_en_next = {NUM_CHAN{1'b0}};
		case (app_mode)
		`DPMC_APP_FULL_BW:  full_bw_next = 1'b1;
		`DPMC_APP_ONE_CHAN: chan_en_next[0] = 1'b1;
		`DPMC_APP_TWO_CHAN: chan_en_next[1:0] = 2'b11;
		// Other codes: all channels idle, full bandwidth off
		default:            chan_en_next = {NUM_CHAN{1'b0}};
		endcase
	end

	// Codes above 100 are undefined; treated as divide by 1
	always @* begin
		case (decim_code)
		`DPMC_DEC_2:  begin phase_max = 4'h1; factor_next = 5'h02; end
		`DPMC_DEC_4:  begin phase_max = 4'h3; factor_next = 5'h04; end
		`DPMC_DEC_8:  begin phase_max = 4'h7; factor_next = 5'h08; end
		`DPMC_DEC_16: begin phase_max = 4'hf; factor_next = 5'h10; end
		default:      begin phase_max = 4'h0; factor_next = 5'h01; end
		endcase
	end

	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_full_bw                  <= 1'b1;
			o_downconverter_channel_en <= {NUM_CHAN{1'b0}};
			o_decim_factor             <= 5'h01;
		end else begin
			o_full_bw                  <= full_bw_next;
			o_downconverter_channel_en <= chan_en_next;
			o_decim_factor             <= factor_next;
		end
	end

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	dpmc_offset_add #(
		.SAMPLE_W (SAMPLE_W)
	) u_add_i (
		.i_sample (i_smp_i),
		.i_offset (offset_reg),
		.o_sum    (adj_i)
	);

	dpmc_offset_add #(
		.SAMPLE_W (SAMPLE_W)
	) u_add_q (
		.i_sample (i_smp_q),
		.i_offset (offset_reg),
		.o_sum    (adj_q)
	);

	// Keeps the first sample of each group; filtering lives elsewhere
	always @(posedge i_mclk) begin
		if (i_rst) begin
			phase_reg     <= 4'h0;
			o_smp_valid   <= 1'b0;
			o_smp_q_valid <= 1'b0;
			o_smp_i       <= {SAMPLE_W{1'b0}};
			o_smp_q       <= {SAMPLE_W{1'b0}};
		end else begin
			o_smp_valid   <= 1'b0;
			o_smp_q_valid <= 1'b0;
			if (i_smp_valid) begin
				if (phase_reg >= phase_max) begin
					phase_reg <= 4'h0;
				end else begin
					phase_reg <= phase_reg + 4'h1;
				end
				if (phase_reg == 4'h0) begin
					o_smp_valid   <= 1'b1;
					o_smp_i       <= adj_i;
					o_smp_q_valid <= ~q_drop;
					o_smp_q       <= q_drop ? {SAMPLE_W{1'b0}} : adj_q;
				end
			end
		end
	end

	// ----------------------------------------
	// Level detect pin
	// ----------------------------------------
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_level_detect_pin <= 1'b0;
		end else if (lvl_ctrl_reg[`DPMC_LVL_FORCE_BIT]) begin
			o_level_detect_pin <= lvl_ctrl_reg[`DPMC_LVL_FVAL_BIT];
		end else begin
			o_level_detect_pin <= lvl_ctrl_reg[`DPMC_LVL_EN_BIT] & i_level_detect_raw;
		end
	end

endmodule // dpmc_datapath_regs

// ===== testbench/dpmc_regs_chk.sv
`timescale 1ns/1ps
module dpmc_regs_chk #(
	parameter SAMPLE_W = 14,
	parameter NUM_CHAN = 4
) (
	// Clock and reset
	input wire                i_mclk,
	input wire                i_rst,
	// Bus handshake
	input wire                i_avs_read,
	input wire                i_avs_write,
	input wire                o_avs_waitrequest,
	// Sample path
	input wire                i_smp_valid,
	input wire                o_smp_valid,
	input wire                o_smp_q_valid,
	input wire [SAMPLE_W-1:0] o_smp_q,
	// Configuration
	input wire                o_full_bw,
	input wire [NUM_CHAN-1:0] o_downconverter_channel_en,
	input wire [4:0]          o_decim_factor
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_req;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	// Kept sample followed by a sample that must be dropped
	sequence s_out2;
		o_smp_valid && i_smp_valid && o_decim_factor == 5'h02 && $stable(o_decim_factor);
	endsequence
	AST_WAIT: assert property (s_req |=> !o_avs_waitrequest)
		else $error("request not answered after one wait state");
	AST_QVALID: assert property (o_smp_q_valid |-> o_smp_valid)
		else $error("quadrature strobe without sample strobe");
	AST_QZERO: assert property (o_smp_valid && !o_smp_q_valid |-> o_smp_q == '0)
		else $error("dropped quadrature not zero");
	AST_FULLBW: assert property (o_full_bw |-> o_downconverter_channel_en == '0)
		else $error("channels enabled in full bandwidth");
	AST_CHEN: assert property (o_downconverter_channel_en inside {4'h0, 4'h1, 4'h3})
		else $error("illegal channel enable pattern");
	AST_DIV: assert property ($onehot(o_decim_factor))
		else $error("decimation factor not a power of two");
	AST_ANS: assert property (o_smp_valid |-> $past(i_smp_valid))
		else $error("output without accepted sample");
	AST_SKIP: assert property (s_out2 |=> !o_smp_valid)
		else $error("odd sample kept at divide by two");
	AST_RST: assert property ($fell(i_rst) |-> o_decim_factor == 5'h01 && o_full_bw)
		else $error("wrong configuration after reset");
endmodule // dpmc_regs_chk

bind dpmc_datapath_regs dpmc_regs_chk #(.SAMPLE_W(SAMPLE_W), .NUM_CHAN(NUM_CHAN)) u_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .i_smp_valid(i_smp_valid), .o_smp_valid(o_smp_valid),
	.o_smp_q_valid(o_smp_q_valid), .o_smp_q(o_smp_q), .o_full_bw(o_full_bw),
	.o_downconverter_channel_en(o_downconverter_channel_en), .o_decim_factor(o_decim_factor));

// ===== testbench/tb_datapath_mode_config_regs.sv
`timescale 1ns/1ps
module tb_datapath_mode_config_regs;
	logic        i_mclk = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0, i_smp_valid = 0, i_level_detect_raw = 0;
	logic [11:0] i_avs_address = 12'h0;
	logic [3:0]  i_avs_byteenable = 4'h1;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [13:0] i_smp_i = 14'h0, i_smp_q = 14'h0;
	wire  [31:0] o_avs_readdata;
	wire         o_avs_waitrequest, o_smp_valid, o_smp_q_valid, o_full_bw, o_level_detect_pin;
	wire  [13:0] o_smp_i, o_smp_q;
	wire  [3:0]  o_downconverter_channel_en;
	wire  [4:0]  o_decim_factor;
	int          n_errors = 0, n_compared = 0, c, n, m;
	logic [31:0] rdv;
	always #2.5 i_mclk = ~i_mclk;
	dpmc_datapath_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_smp_valid(i_smp_valid), .i_smp_i(i_smp_i), .i_smp_q(i_smp_q), .o_smp_valid(o_smp_valid),
		.o_smp_q_valid(o_smp_q_valid), .o_smp_i(o_smp_i), .o_smp_q(o_smp_q), .o_full_bw(o_full_bw),
		.o_downconverter_channel_en(o_downconverter_channel_en), .o_decim_factor(o_decim_factor),
		.i_level_detect_raw(i_level_detect_raw), .o_level_detect_pin(o_level_detect_pin));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Holds the request until waitrequest is sampled low at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge i_mclk);
		i_avs_read <= !w;
		i_avs_write <= w;
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		@(posedge i_mclk);
		while (o_avs_waitrequest !== 1'b0) begin
			k++;
			if (k > 50) begin
				n_errors++;
				conclude;
			end
			@(posedge i_mclk);
		end
		rdv = o_avs_readdata;
		i_avs_read <= 0;
		i_avs_write <= 0;
	endtask
	task settle;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask
	task smp(input logic [13:0] si, input logic [13:0] sq);
		@(posedge i_mclk);
		i_smp_valid <= 1;
		i_smp_i <= si;
		i_smp_q <= sq;
		@(posedge i_mclk);
		i_smp_valid <= 0;
		#1;
		chk(o_smp_valid, 1);
	endtask
	task t_rst;
		xfer(0, 12'h800, 0); chk(rdv, 0);
		xfer(0, 12'h804, 0); chk(rdv, 0);
		xfer(0, 12'h8a0, 0); chk(rdv, 0);
		xfer(0, 12'h914, 0); chk(rdv, 0);
		chk({o_full_bw, o_downconverter_channel_en, o_decim_factor, o_level_detect_pin}, 32'h402);
		// Write with lane 0 disabled must store nothing
		i_avs_byteenable <= 4'h0;
		xfer(1, 12'h800, 8'h2f);
		i_avs_byteenable <= 4'h1;
		xfer(0, 12'h800, 0); chk(rdv, 0);
		xfer(1, 12'h004, 8'hff);
		xfer(0, 12'h004, 0); chk(rdv, 0);
		$display("t_rst done");
	endtask
	task t_mode;
		for (c = 0; c < 4; c++) begin
			xfer(1, 12'h800, c[7:0]);
			settle;
			chk(o_full_bw, c == 0);
			chk(o_downconverter_channel_en, c == 1 ? 1 : c == 2 ? 3 : 0);
		end
		xfer(1, 12'h800, 8'hff);
		xfer(0, 12'h800, 0); chk(rdv, 32'hef);
		$display("t_mode done");
	endtask
	task t_lvl;
		xfer(1, 12'h914, 8'h01);
		i_level_detect_raw <= 1;
		settle; chk(o_level_detect_pin, 1);
		xfer(1, 12'h914, 8'h08);
		settle; chk(o_level_detect_pin, 0);
		xfer(1, 12'h914, 8'h0c);
		i_level_detect_raw <= 0;
		settle; chk(o_level_detect_pin, 1);
		xfer(0, 12'h914, 0); chk(rdv, 32'h0c);
		$display("t_lvl done");
	endtask
	task t_off;
		xfer(1, 12'h800, 8'h00);
		xfer(1, 12'h8a0, 8'h80);
		smp(14'h0064, 14'h20c0); chk({o_smp_q_valid, o_smp_i, o_smp_q}, {1'b1, 14'h3fe4, 14'h2040});
		xfer(1, 12'h8a0, 8'h7f);
		smp(14'h1fff, 14'h2000); chk({o_smp_i, o_smp_q}, {14'h1fff, 14'h207f});
		xfer(1, 12'h800, 8'h20);
		settle;
		smp(14'h0000, 14'h0010); chk({o_smp_q_valid, o_smp_i, o_smp_q}, {1'b0, 14'h007f, 14'h0});
		$display("t_off done");
	endtask
	task t_dec;
		for (c = 0; c < 5; c++) begin
			xfer(1, 12'h804, c[7:0]);
			settle; chk(o_decim_factor, 1 << c);
		end
		// Sixteen back-to-back samples at divide by two, then by four
		for (m = 1; m < 3; m++) begin
			xfer(1, 12'h804, m[7:0]);
			settle;
			n = 0;
			for (c = 0; c < 18; c++) begin
				@(posedge i_mclk);
				i_smp_valid <= (c < 16);
				#1;
				n += o_smp_valid;
				chk(o_smp_valid, c > 0 && c < 17 && (c - 1) % (1 << m) == 0);
			end
			chk(n, 16 >> m);
		end
		$display("t_dec done");
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 0;
		t_rst; t_mode; t_lvl; t_off; t_dec;
		conclude;
	end
	initial begin
		#100000;
		n_errors++;
		conclude;
	end
endmodule // tb_datapath_mode_config_regs
